// ===== hdl/sys_decoder_regs.svh
// Encodings and fixed field positions shared by the address decoder files.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SYS_DECODER_REGS_SVH
`define SYS_DECODER_REGS_SVH

// Transfer type codes on the two trans_type pins
`define TRANS_ADDR_ONLY 2'h0
`define TRANS_RESERVED 2'h1
`define TRANS_NONSEQ 2'h2
`define TRANS_SEQ 2'h3

// Transfer size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Protection bit that marks a privileged access
`define PROT_PRIV_BIT 1

// Low address bits that carry byte lane alignment
`define ADDR_LANE_MSB 1
`define ADDR_LANE_LSB 0
`define WORD_LOW_BIT 2

// Default region granule for boundary detection, as address bits
`define BOUNDARY_BITS_DEFAULT 10

`endif

// ===== hdl/sys_decoder_pkg.sv
// Types for the system bus address decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package sys_decoder_pkg;

  typedef enum logic [1:0] {
    addr_only_state = 2'b00,
    decode_state = 2'b01,
    slave_selected_state = 2'b10,
    error_state = 2'b11
  } dec_state_e;

  typedef logic [1:0] trans_t;

endpackage : sys_decoder_pkg

// ===== hdl/slave_match.sv
// One slave region: address match and privilege check.
// Assumes the address is held stable by the granted master while sampled.
`timescale 1ns/1ps
`default_nettype none
`include "sys_decoder_regs.svh"

module slave_match #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'hF000_0000,
  parameter bit PRIV_ONLY = 1'b0
) (
  input wire logic [31:0] addr_in,
  input wire logic [1:0] prot_in,
  output logic hit_out,
  output logic prot_fault_out
);

  always_comb begin
    hit_out = ((addr_in & MASK) == (BASE & MASK));
    // A user-mode access to a privileged region counts as a protection fault
    prot_fault_out = hit_out && PRIV_ONLY && !prot_in[`PROT_PRIV_BIT];
  end

endmodule : slave_match

`default_nettype wire

// ===== hdl/system_bus_address_decoder.sv
// Central address decoder for the shared system bus: one select per slave,
// default response for address-only cycles, protection and alignment errors.
// Assumes one granted master drives address and transfer type, the
// testbench resolves the shared response wires from the enable output.
//
// Notes on behaviour
// - Drive one select per slave; sometimes select none and answer the master itself.
// - Insert a decode wait cycle on nonsequential transfers, and on sequential ones after LAST, a boundary or an error.
// - Answer ERROR to accesses to illegal or protected regions.
// - Drive the response itself during address-only transfers.
// - Four-state machine clocked on the falling clock edge.
// - Reset puts the machine in the address-only state.
// - Next state from next type, current response, boundary flag, fault flag.
// - Not-wait means DONE, LAST, ERROR or RETRACT.
// - Boundary flag forces a fresh decode for sequential transfers, as LAST does.
// - Fault on no slave, protected region, or unsupported alignment.
// - Address-only: DONE, select only when next is sequential and valid.
// - Decode: WAIT, then select the matching slave when the address is valid.
// - Slave-selected: slave answers; select held while waited or plain sequential.
// - Error state: decoder drives ERROR.
// - Normal variant breaks bursts at memory boundaries with a decode cycle.
// - Low-speed variant omits the decode state entirely.
`timescale 1ns/1ps
`default_nettype none
`include "sys_decoder_regs.svh"

module system_bus_address_decoder
  import sys_decoder_pkg::*;
#(
  parameter int N_SLAVES = 4,
  parameter bit DECODE_CYCLES = 1'b1,
  parameter int BOUNDARY_BITS = `BOUNDARY_BITS_DEFAULT,
  parameter logic [N_SLAVES*32-1:0] SLAVE_BASE = {32'h3000_0000, 32'h2000_0000, 32'h1000_0000, 32'h0000_0000},
  parameter logic [N_SLAVES*32-1:0] SLAVE_MASK = {N_SLAVES{32'hF000_0000}},
  parameter logic [N_SLAVES-1:0] SLAVE_PRIV = '0,
  parameter logic [N_SLAVES-1:0] SLAVE_NO_SUBWORD = '0
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire sys_decoder_pkg::trans_t trans_type_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0] size_in,
  input wire logic [1:0] prot_in,
  input wire logic resp_wait_in,
  input wire logic resp_error_in,
  input wire logic resp_last_in,
  output logic resp_wait_out,
  output logic resp_error_out,
  output logic resp_last_out,
  output logic resp_oe_out,
  output logic [N_SLAVES-1:0] slave_select_out
);

  if (N_SLAVES < 1 || N_SLAVES > 32) begin : g_bad_slaves
    $error("N_SLAVES must lie between 1 and 32");
  end
  if (BOUNDARY_BITS < 3 || BOUNDARY_BITS > 31) begin : g_bad_boundary
    $error("BOUNDARY_BITS must lie between 3 and 31");
  end

  logic [N_SLAVES-1:0] hit;
  logic [N_SLAVES-1:0] prot_fault;
  logic any_hit;
  logic align_fault;
  logic decode_fault_flag;
  logic boundary_last_now;
  logic resp_not_wait;
  logic next_is_seq;
  logic next_is_nonseq;
  logic fresh_decode;

  dec_state_e state_reg, state_next;
  logic boundary_last_flag_reg, boundary_last_flag_next;
  logic [N_SLAVES-1:0] held_hit_reg, held_hit_next;
  logic resp_wait_reg, resp_wait_next;
  logic resp_error_reg, resp_error_next;
  logic resp_oe_reg, resp_oe_next;
  logic [N_SLAVES-1:0] select_reg, select_next;

  // One matcher per slave region
  for (genvar i = 0; i < N_SLAVES; i++) begin : g_match
    slave_match #(
      .BASE(SLAVE_BASE[i*32 +: 32]),
      .MASK(SLAVE_MASK[i*32 +: 32]),
      .PRIV_ONLY(SLAVE_PRIV[i])
    ) u_match (
      .addr_in(addr_in),
      .prot_in(prot_in),
      .hit_out(hit[i]),
      .prot_fault_out(prot_fault[i])
    );
  end

  always_comb begin
    any_hit = |hit;
    // Half words need an even address, words a word-aligned one
    align_fault = 1'b0;
    unique case (size_in)
      `SIZE_BYTE: align_fault = 1'b0;
      `SIZE_HALF: align_fault = addr_in[`ADDR_LANE_LSB];
      `SIZE_WORD: align_fault = |addr_in[`ADDR_LANE_MSB:`ADDR_LANE_LSB];
      default: align_fault = 1'b1;
    endcase
    if ((hit & SLAVE_NO_SUBWORD) != '0 && size_in != `SIZE_WORD) begin
      align_fault = 1'b1;
    end
    decode_fault_flag = !any_hit || (|prot_fault) || align_fault;
    // Last word of a region: the following sequential beat would cross it
    boundary_last_now = &addr_in[BOUNDARY_BITS-1:`WORD_LOW_BIT];
    // Waited only when wait is up with neither error nor last
    resp_not_wait = !(resp_wait_in && !resp_error_in && !resp_last_in);
    next_is_seq = (trans_type_in == `TRANS_SEQ);
    next_is_nonseq = (trans_type_in == `TRANS_NONSEQ);
    // LAST or the boundary flag break a burst just like a nonsequential beat
    fresh_decode = next_is_nonseq ||
                   (next_is_seq && (resp_last_in || boundary_last_flag_reg));
  end

  // Falling-edge state group
  always_comb begin
    state_next = state_reg;
    held_hit_next = held_hit_reg;
    boundary_last_flag_next = boundary_last_flag_reg;
    unique case (state_reg)
      addr_only_state: begin
        if (next_is_nonseq) begin
          if (DECODE_CYCLES) begin
            state_next = decode_state;
          end else begin
            state_next = decode_fault_flag ? error_state : slave_selected_state;
          end
        end else if (next_is_seq) begin
          state_next = decode_fault_flag ? error_state : slave_selected_state;
        end else begin
          state_next = addr_only_state;
        end
      end
      decode_state: begin
        state_next = decode_fault_flag ? error_state : slave_selected_state;
      end
      slave_selected_state: begin
        if (resp_not_wait) begin
          if (trans_type_in == `TRANS_ADDR_ONLY || trans_type_in == `TRANS_RESERVED) begin
            state_next = addr_only_state;
          end else if (fresh_decode) begin
            if (DECODE_CYCLES) begin
              state_next = decode_state;
            end else begin
              state_next = decode_fault_flag ? error_state : slave_selected_state;
            end
          end else begin
            state_next = slave_selected_state;
          end
        end
      end
      error_state: begin
        if (next_is_nonseq || next_is_seq) begin
          if (DECODE_CYCLES) begin
            state_next = decode_state;
          end else begin
            state_next = decode_fault_flag ? error_state : slave_selected_state;
          end
        end else begin
          state_next = addr_only_state;
        end
      end
    endcase
    // Capture the slave on every fresh entry; a plain sequential beat keeps it.
    // A waited beat must not pick up a new slave even if the next type asks for a decode.
    if (state_next == slave_selected_state &&
        (state_reg != slave_selected_state || (fresh_decode && resp_not_wait))) begin
      held_hit_next = hit;
      boundary_last_flag_next = boundary_last_now;
    end else if (state_reg == slave_selected_state && resp_not_wait) begin
      boundary_last_flag_next = boundary_last_now;
    end
    if (state_next != slave_selected_state) begin
      boundary_last_flag_next = 1'b0;
    end
    // Own response whenever no slave is selected
    resp_oe_next = (state_next != slave_selected_state);
    resp_wait_next = (state_next == decode_state);
    resp_error_next = (state_next == error_state);
    if (reset_in) begin
      state_next = addr_only_state;
      held_hit_next = '0;
      boundary_last_flag_next = 1'b0;
      resp_oe_next = 1'b1;
      resp_wait_next = 1'b0;
      resp_error_next = 1'b0;
    end
  end

  always_ff @(negedge core_clk_in) begin
    state_reg <= state_next;
    held_hit_reg <= held_hit_next;
    boundary_last_flag_reg <= boundary_last_flag_next;
    resp_oe_reg <= resp_oe_next;
    resp_wait_reg <= resp_wait_next;
    resp_error_reg <= resp_error_next;
  end

  // Rising-edge select group: selects change in the high phase
  always_comb begin
    select_next = '0;
    unique case (state_reg)
      addr_only_state: begin
        // Speculative decode, offered only ahead of a sequential beat
        if (next_is_seq && !decode_fault_flag) begin
          select_next = hit;
        end
      end
      decode_state: begin
        if (!decode_fault_flag) begin
          select_next = hit;
        end
      end
      slave_selected_state: select_next = held_hit_reg;
      error_state: select_next = '0;
    endcase
    if (reset_in) begin
      select_next = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    select_reg <= select_next;
  end

  always_comb begin
    resp_oe_out = resp_oe_reg;
    resp_wait_out = resp_wait_reg;
    resp_error_out = resp_error_reg;
    // The decoder never signals LAST on its own behalf
    resp_last_out = 1'b0;
    slave_select_out = select_reg;
  end

  sequence s_fault_seen;
    state_reg == decode_state && decode_fault_flag;
  endsequence

  sequence s_error_answer;
    state_reg == error_state && resp_oe_reg && resp_error_reg && !resp_wait_reg;
  endsequence

  a_reset_addr_only: assert property (@(negedge core_clk_in) reset_in |=> state_reg == addr_only_state && resp_oe_reg)
    else $error("reset did not reach the address-only state");

  a_fault_to_error: assert property (@(negedge core_clk_in) disable iff (reset_in) s_fault_seen |=> s_error_answer)
    else $error("decode fault did not give an error answer");

  a_decode_waits: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == decode_state |-> resp_oe_reg && resp_wait_reg && !resp_error_reg)
    else $error("decode cycle without own wait answer");

  a_addr_only_done: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == addr_only_state |-> resp_oe_reg && !resp_wait_reg && !resp_error_reg)
    else $error("address-only cycle without own done answer");

  a_no_select_err: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $past(state_reg == error_state) && !reset_in |-> slave_select_out == '0)
    else $error("select asserted in the error state");

  a_select_onehot: assert property (@(posedge core_clk_in) disable iff (reset_in) $onehot0(slave_select_out))
    else $error("more than one slave selected");

  a_seq_holds_sel: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == slave_selected_state && !resp_not_wait |=> state_reg == slave_selected_state
      && held_hit_reg == $past(held_hit_reg))
    else $error("waited transfer lost its slave");

  a_nonseq_decodes: assert property (@(negedge core_clk_in) disable iff (reset_in)
    DECODE_CYCLES && state_reg == slave_selected_state && resp_not_wait && next_is_nonseq
      |=> state_reg == decode_state ##1 state_reg != decode_state)
    else $error("nonsequential transfer skipped its single decode cycle");

  a_boundary_breaks: assert property (@(negedge core_clk_in) disable iff (reset_in)
    DECODE_CYCLES && state_reg == slave_selected_state && resp_not_wait && next_is_seq
      && boundary_last_flag_reg |=> state_reg == decode_state)
    else $error("burst crossed a boundary without a decode cycle");

  a_idle_returns: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == error_state && trans_type_in == `TRANS_ADDR_ONLY
      |=> state_reg == addr_only_state && resp_oe_reg && !resp_error_reg)
    else $error("no return to the address-only state");

  a_waited_keeps: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == slave_selected_state && !resp_not_wait |=> !resp_oe_reg
      && boundary_last_flag_reg == $past(boundary_last_flag_reg))
    else $error("waited transfer changed its answer owner or boundary flag");

  a_seq_no_decode: assert property (@(negedge core_clk_in) disable iff (reset_in)
    state_reg == slave_selected_state && resp_not_wait && next_is_seq && !resp_last_in
      && !boundary_last_flag_reg |=> state_reg == slave_selected_state && !resp_oe_reg)
    else $error("plain sequential beat paid a decode cycle");

endmodule : system_bus_address_decoder

`default_nettype wire

// ===== sim/bus_slave_model.sv
// Behavioural slave side: answers for whichever select is high.
// Assumes the decoder enable output marks when it owns the response wires.
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model #(
  parameter int N = 4
) (
  input wire logic clk_in,
  input wire logic [N-1:0] select_in,
  input wire logic oe_in,
  input wire logic wait_in,
  input wire logic error_in,
  input wire logic last_in,
  input wire logic [3:0] waits_in,
  input wire logic last_en_in,
  output logic wait_out,
  output logic error_out,
  output logic last_out
);
  logic [3:0] cnt_reg = 4'h0;
  logic flip_reg = 1'b0;
  logic drive;
  logic busy;
  assign drive = |select_in && !oe_in;
  assign busy = cnt_reg != waits_in;
  always @(negedge clk_in) begin
    flip_reg <= !flip_reg;
    cnt_reg <= (drive && busy) ? cnt_reg + 4'h1 : 4'h0;
  end
  // Undriven wires wander so a stale DONE is never read by chance
  always_comb begin
    if (oe_in) begin
      {wait_out, error_out, last_out} = {wait_in, error_in, last_in};
    end else if (drive) begin
      {wait_out, error_out, last_out} = {busy, 1'b0, !busy && last_en_in};
    end else begin
      {wait_out, error_out, last_out} = {flip_reg, !flip_reg, flip_reg};
    end
  end
endmodule : bus_slave_model
`default_nettype wire

// ===== sim/system_bus_address_decoder_tb.sv
// Bench for the address decoder: full variant checked step by step, low-speed
// variant beside it on the same master inputs. Assumes hdl/ on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sys_decoder_regs.svh"
module system_bus_address_decoder_tb;
  import sys_decoder_pkg::*;
  localparam logic [3:0] R_DONE = 4'h4;
  localparam logic [3:0] R_DEC = 4'h6;
  localparam logic [3:0] R_ERR = 4'h5;
  localparam logic [3:0] R_SLV = 4'h0;
  localparam logic [3:0] SKIP = 4'hF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  trans_t ttype = `TRANS_ADDR_ONLY;
  logic [31:0] addr = 32'h0;
  logic [1:0] size = `SIZE_WORD;
  logic [1:0] prot = 2'h2;
  logic [3:0] waits = 4'h0;
  logic last_en = 1'b0;
  wire [2:0] rin [2];
  wire [2:0] dout [2];
  wire [1:0] oe;
  wire [3:0] sel [2];
  logic [3:0] rsp;
  int errors = 0;
  int samples_checked = 0;
  assign rsp = {dout[0][0], oe[0], oe[0] & dout[0][2], oe[0] & dout[0][1]};
  always #20 clk = ~clk;
  for (genvar g = 0; g < 2; g++) begin : lane
    system_bus_address_decoder #(
      .DECODE_CYCLES(g == 0),
      .SLAVE_PRIV(4'h8),
      .SLAVE_NO_SUBWORD(4'h4)
    ) system_bus_address_decoder_inst (
      .core_clk_in(clk),
      .reset_in(rst),
      .trans_type_in(ttype),
      .addr_in(addr),
      .size_in(size),
      .prot_in(prot),
      .resp_wait_in(rin[g][2]),
      .resp_error_in(rin[g][1]),
      .resp_last_in(rin[g][0]),
      .resp_wait_out(dout[g][2]),
      .resp_error_out(dout[g][1]),
      .resp_last_out(dout[g][0]),
      .resp_oe_out(oe[g]),
      .slave_select_out(sel[g])
    );
    bus_slave_model #(
      .N(4)
    ) bus_slave_model_inst (
      .clk_in(clk),
      .select_in(sel[g]),
      .oe_in(oe[g]),
      .wait_in(dout[g][2]),
      .error_in(dout[g][1]),
      .last_in(dout[g][0]),
      .waits_in(waits),
      .last_en_in(last_en),
      .wait_out(rin[g][2]),
      .error_out(rin[g][1]),
      .last_out(rin[g][0])
    );
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Drives the next transfer, then judges what the current edge produced
  task automatic step(input trans_t t, input logic [31:0] a, input logic [3:0] r, input logic [3:0] s);
    @(negedge clk);
    ttype <= t;
    addr <= a;
    #1;
    if (r !== SKIP) chk({4'h0, rsp}, {4'h0, r});
    @(posedge clk);
    #1;
    if (s !== SKIP) chk({4'h0, sel[0]}, {4'h0, s});
  endtask : step
  task automatic setup(input logic [1:0] sz, input logic [1:0] pr, input logic [3:0] n);
    @(negedge clk);
    size <= sz;
    prot <= pr;
    waits <= n;
  endtask : setup
  task automatic nonseq(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] pr, input logic [3:0] hit,
                        input logic [3:0] n);
    setup(sz, pr, n);
    step(`TRANS_NONSEQ, a, R_DONE, 4'h0);
    step(`TRANS_ADDR_ONLY, a, R_DEC, hit);
    chk({7'h0, oe[1]}, {7'h0, hit == 4'h0});
    if (hit == 4'h0) begin
      step(`TRANS_ADDR_ONLY, a, R_ERR, 4'h0);
    end else begin
      repeat (n) step(`TRANS_ADDR_ONLY, a, R_SLV, hit);
      step(`TRANS_ADDR_ONLY, a, R_SLV, SKIP);
    end
    step(`TRANS_ADDR_ONLY, a, R_DONE, 4'h0);
    $display("nonsequential test to %h done", a);
  endtask : nonseq
  task automatic seq_burst();
    setup(`SIZE_WORD, 2'h2, 4'h1);
    step(`TRANS_SEQ, 32'h0000_0100, R_DONE, 4'h1);
    step(`TRANS_SEQ, 32'h0000_0104, R_SLV, 4'h1);
    last_en = 1'b1;
    step(`TRANS_SEQ, 32'h0000_0108, R_SLV, SKIP);
    // LAST must still stand at the falling edge that ends the beat
    step(`TRANS_ADDR_ONLY, 32'h0000_0108, R_DEC, 4'h1);
    last_en = 1'b0;
    step(`TRANS_ADDR_ONLY, 32'h0000_0108, R_SLV, 4'h1);
    step(`TRANS_ADDR_ONLY, 32'h0000_0108, R_SLV, SKIP);
    step(`TRANS_ADDR_ONLY, 32'h0000_0108, R_DONE, 4'h0);
    $display("sequential burst test done");
  endtask : seq_burst
  // Two nonsequential transfers back to back: each pays exactly one decode cycle
  task automatic back_to_back();
    setup(`SIZE_WORD, 2'h2, 4'h0);
    step(`TRANS_NONSEQ, 32'h1000_0000, R_DONE, 4'h0);
    step(`TRANS_NONSEQ, 32'h1000_0000, R_DEC, 4'h2);
    step(`TRANS_NONSEQ, 32'h2000_0000, R_SLV, 4'h2);
    step(`TRANS_ADDR_ONLY, 32'h2000_0000, R_DEC, 4'h4);
    step(`TRANS_ADDR_ONLY, 32'h2000_0000, R_SLV, 4'h4);
    step(`TRANS_ADDR_ONLY, 32'h2000_0000, R_DONE, 4'h0);
    $display("back-to-back nonsequential test done");
  endtask : back_to_back
  // A burst over the 1 KiB edge must be broken by exactly one decode cycle
  task automatic boundary();
    int dec;
    dec = 0;
    setup(`SIZE_WORD, 2'h2, 4'h0);
    for (int k = 0; k < 6; k++) begin
      step(k < 4 ? `TRANS_SEQ : `TRANS_ADDR_ONLY, 32'h0000_03F8 + 32'(k * 4), SKIP, SKIP);
      if (rsp === R_DEC) dec++;
    end
    chk(8'(dec), 8'h01);
    $display("boundary test done");
  endtask : boundary
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk({4'h0, rsp}, {4'h0, R_DONE});
    chk({4'h0, sel[0]}, 8'h00);
    @(negedge clk);
    rst <= 1'b0;
    $display("reset test done");
    nonseq(32'h1000_0040, `SIZE_WORD, 2'h2, 4'h2, 4'h2);
    nonseq(32'h2000_0000, `SIZE_WORD, 2'h0, 4'h4, 4'h0);
    nonseq(32'h3000_0010, `SIZE_HALF, 2'h2, 4'h8, 4'h1);
    nonseq(32'h8000_0000, `SIZE_WORD, 2'h2, 4'h0, 4'h0);
    nonseq(32'h3000_0000, `SIZE_WORD, 2'h0, 4'h0, 4'h0);
    nonseq(32'h2000_0001, `SIZE_BYTE, 2'h2, 4'h0, 4'h0);
    nonseq(32'h0000_0000, 2'h3, 2'h2, 4'h0, 4'h0);
    back_to_back();
    seq_burst();
    boundary();
    give_verdict();
  end
endmodule : system_bus_address_decoder_tb
`default_nettype wire
